// >>> atc_regs.svh
// constants for the task-file command block: opcodes, bit positions, counts
// assumes nothing; definitions only, included by bare name
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH
`define ATC_OP_STBY_A 8'h96
`define ATC_OP_STBY_B 8'he2
`define ATC_OP_STBYI_A 8'h94
`define ATC_OP_STBYI_B 8'he0
`define ATC_OP_XLATE 8'h87
`define ATC_OP_WEAR 8'hf5
`define ATC_OP_WRBUF 8'he8
`define ATC_OP_WRDMA 8'hca
// drive/head field layout
`define ATC_DH_DRV 4
`define ATC_DH_LBA 6
`define ATC_DH_HEAD 3:0
// error register bits
`define ATC_ERR_ABRT 2
`define ATC_ERR_IDNF 4
`define ATC_ERR_NONE 8'h00
// 512 bytes per sector is 256 words; count 0 means 256 sectors
`define ATC_WORD_LAST 8'hff
`define ATC_WORD_ZERO 8'h00
`define ATC_ZERO_COUNT 8'h00
`define ATC_SEC_256 9'h100
`define ATC_ONE_SEC 9'h001
`define ATC_WORD_SHIFT 8'h00
// chs geometry
`define ATC_SEC_FIRST 8'h01
`define ATC_SEC_PER_TRK 8'h3f
`define ATC_HEAD_LAST 4'hf
// two-entry buffer fill levels
`define ATC_BUF_EMPTY 2'h0
`define ATC_BUF_FULL 2'h2
`endif

// >>> atc_pkg.sv
// types shared by the command core and its data buffer
// assumes atc_regs.svh supplies the numeric constants
package atc_pkg;
  // task-file register set, as written by the host
  typedef struct packed {
    logic [7:0] features;
    logic [7:0] secCount;
    logic [7:0] secNum;
    logic [7:0] cylLow;
    logic [7:0] cylHigh;
    logic [7:0] drvHead;
  } atc_taskfile_t;
  // one data word on its way to the media
  typedef struct packed {
    logic [15:0] data;
    logic sectorEnd;
  } atc_word_t;
  // decoded command classes
  typedef enum logic [2:0] {CMD_NONE, CMD_STBY, CMD_NOP, CMD_WRBUF, CMD_WRDMA} atc_cmd_t;
  // command sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PIO, ST_DMA, ST_FINISH} atc_state_t;
endpackage

// >>> atc_skid_buf.sv
// two-entry buffer between the host write stream and the media
// assumes one clock; outputs are registers except inReady, a decode of the count; flush empties it at once
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.svh"
module atc_skid_buf
  import atc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire atc_word_t inData,
  output logic outValid,
  input wire logic outReady,
  output atc_word_t outData,
  output logic [1:0] count
);
  logic [1:0] cnt_ff; // words held
  logic outValid_ff; // head holds a word
  atc_word_t head_ff; // oldest word, drives the output
  atc_word_t tail_ff; // second word, only while full
  logic push; // word taken in
  logic pop; // word given out
  logic [1:0] nxt_cnt; // fill after this cycle

  assign inReady = (cnt_ff != `ATC_BUF_FULL);
  assign push = inValid && inReady;
  assign pop = outValid_ff && outReady;
  assign outValid = outValid_ff;
  assign outData = head_ff;
  assign count = cnt_ff;

  // fill level; flush wins so an aborted write leaves nothing behind
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (flush)
      nxt_cnt = `ATC_BUF_EMPTY;
    else if (push && !pop)
      nxt_cnt = cnt_ff + 2'h1;
    else if (pop && !push)
      nxt_cnt = cnt_ff - 2'h1;
  end

  // counters
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_ff <= `ATC_BUF_EMPTY;
      outValid_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      cnt_ff <= nxt_cnt;
      outValid_ff <= (nxt_cnt != `ATC_BUF_EMPTY);
    end
  end

  // data shifts from tail to head; no reset needed on a data path, but kept defined
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      head_ff <= '0;
      tail_ff <= '0;
    end
    else if (clkEn)
    begin
      if (pop)
      begin
        if (cnt_ff == `ATC_BUF_FULL)
          head_ff <= tail_ff;
        else if (push)
          head_ff <= inData;
        if (push && cnt_ff == `ATC_BUF_FULL)
          tail_ff <= inData;
      end
      else if (push)
      begin
        if (cnt_ff == `ATC_BUF_EMPTY)
          head_ff <= inData;
        else
          tail_ff <= inData;
      end
    end
  end
endmodule
`default_nettype wire

// >>> atc_cmd_core.sv
// standby, no-op, write-buffer and dma-write command execution
// assumes the host keeps the task-file protocol; inputs synchronous
//
// Function
// RULE_01: standby: busy, sleep, unbusy, interrupt at once
// RULE_02: standby immediate behaves the same way
// RULE_03: any new command wakes the sleeping device
// RULE_04: translate sector: no-op, sector count zero
// RULE_05: wear level: no-op, sector count zero
// RULE_06: write buffer takes one 512-byte block
// RULE_07: dma write count 1..256, zero means 256
// RULE_08: dma write starts at task-file address
// RULE_09: dma write sets busy, then drq
// RULE_10: dma request held while data accepted
// RULE_11: host acknowledges, one strobe per word
// RULE_12: host sends 512 bytes per sector
// RULE_13: dma write interrupts only at end or error
// RULE_14: done: address of last sector written
// RULE_15: error: stop, keep failing sector address
// RULE_16: 8-bit mode aborts dma write
// RULE_17: sector-write protocol: drq without first interrupt
// RULE_18: decode only opcode and drive bit
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.svh"
module atc_cmd_core
  import atc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic devSelect,
  input wire logic eightBitMode,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire atc_taskfile_t tfIn,
  input wire logic statusRead,
  input wire logic hostWrStrobe,
  input wire logic [15:0] hostWrData,
  input wire logic dmaAckN,
  input wire logic mediaReady,
  input wire logic mediaErr,
  input wire logic [7:0] sbRdAddr,
  output logic busy,
  output logic drq,
  output logic intrq,
  output logic dmaReq,
  output logic sleeping,
  output logic [7:0] errorReg,
  output logic errStat,
  output atc_taskfile_t tfOut,
  output logic mediaValid,
  output atc_word_t mediaWord,
  output logic [15:0] sbRdData
);
  // opcode classes; unused task-file fields never enter the decode
  function automatic atc_cmd_t cmdKind(input logic [7:0] code);
    case (code)
      `ATC_OP_STBY_A, `ATC_OP_STBY_B, `ATC_OP_STBYI_A, `ATC_OP_STBYI_B: cmdKind = CMD_STBY;
      `ATC_OP_XLATE, `ATC_OP_WEAR: cmdKind = CMD_NOP;
      `ATC_OP_WRBUF: cmdKind = CMD_WRBUF;
      `ATC_OP_WRDMA: cmdKind = CMD_WRDMA;
      default: cmdKind = CMD_NONE;
    endcase
  endfunction

  // next sector address, lba or chs
  function automatic atc_taskfile_t nextAddr(input atc_taskfile_t t);
    atc_taskfile_t r;
    logic [27:0] lba;
    r = t;
    lba = {t.drvHead[`ATC_DH_HEAD], t.cylHigh, t.cylLow, t.secNum} + 28'h1;
    if (t.drvHead[`ATC_DH_LBA])
      {r.drvHead[`ATC_DH_HEAD], r.cylHigh, r.cylLow, r.secNum} = lba;
    else if (t.secNum != `ATC_SEC_PER_TRK)
      r.secNum = t.secNum + 8'h01;
    else
    begin
      r.secNum = `ATC_SEC_FIRST;
      if (t.drvHead[`ATC_DH_HEAD] != `ATC_HEAD_LAST)
        r.drvHead[`ATC_DH_HEAD] = t.drvHead[`ATC_DH_HEAD] + 4'h1;
      else
      begin
        r.drvHead[`ATC_DH_HEAD] = 4'h0;
        {r.cylHigh, r.cylLow} = {t.cylHigh, t.cylLow} + 16'h1;
      end
    end
    return r;
  endfunction

  atc_state_t state_ff; // sequencer state
  atc_cmd_t cmd_ff; // command being run
  atc_taskfile_t tf_ff; // task-file image shown to the host
  logic busy_ff; // status busy
  logic drq_ff; // status data request
  logic intrq_ff; // host interrupt, level until status read or new command
  logic dmaReq_ff; // dma request pin
  logic sleep_ff; // low-power state
  logic [7:0] err_ff; // error register
  logic errStat_ff; // status error bit
  logic [7:0] wordCnt_ff; // host words within the sector
  logic [8:0] sectLeft_ff; // sectors still to reach the media
  logic [16:0] hostLeft_ff; // dma words still due from the host
  logic [15:0] sbRdData_ff; // sector buffer read data
  logic [15:0] secBuf [0:255]; // one sector of write-buffer data

  logic cmdTaken; // command accepted this cycle
  atc_cmd_t kind; // class of the incoming opcode
  logic pioWord; // pio word taken
  logic dmaWord; // dma word taken
  logic bufReady; // buffer has room
  logic bufValid; // word waiting for the media
  logic [1:0] bufCount; // buffer fill
  logic bufFlush; // drop buffered words on error
  logic mediaPop; // media took a word
  logic secDone; // media took the last word of a sector
  logic dmaErr; // media reported a failure
  logic bufFullNext; // buffer full after this cycle
  logic [16:0] hostLeftNext; // host words due after this cycle
  atc_word_t pushWord; // word entering the buffer

  assign kind = cmdKind(cmdCode);
  // only this drive's bit is looked at; busy commands are ignored
  assign cmdTaken = cmdWrite && (tfIn.drvHead[`ATC_DH_DRV] == devSelect) && state_ff == ST_IDLE
                    && kind != CMD_NONE; // [RULE_18]
  assign pioWord = state_ff == ST_PIO && drq_ff && hostWrStrobe && dmaAckN; // [RULE_06]
  // a word counts only with acknowledge low and request high
  assign dmaWord = state_ff == ST_DMA && dmaReq_ff && !dmaAckN && hostWrStrobe && bufReady; // [RULE_11]
  assign mediaPop = bufValid && mediaReady;
  assign secDone = mediaPop && mediaWord.sectorEnd;
  assign dmaErr = state_ff == ST_DMA && mediaErr;
  assign bufFlush = dmaErr;
  assign pushWord = '{data: hostWrData, sectorEnd: (wordCnt_ff == `ATC_WORD_LAST)};
  assign hostLeftNext = dmaWord ? hostLeft_ff - 17'h1 : hostLeft_ff;
  // full after this cycle: count plus push minus pop
  assign bufFullNext = (bufCount + {1'b0, dmaWord} - {1'b0, mediaPop}) == `ATC_BUF_FULL;

  assign busy = busy_ff;
  assign drq = drq_ff;
  assign intrq = intrq_ff;
  assign dmaReq = dmaReq_ff;
  assign sleeping = sleep_ff;
  assign errorReg = err_ff;
  assign errStat = errStat_ff;
  assign tfOut = tf_ff;
  assign mediaValid = bufValid;
  assign sbRdData = sbRdData_ff;

  // stall on the media side backs up into the request pin, so no word is dropped
  atc_skid_buf u_buf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .flush(bufFlush),
    .inValid(dmaWord),
    .inReady(bufReady),
    .inData(pushWord),
    .outValid(bufValid),
    .outReady(mediaReady),
    .outData(mediaWord),
    .count(bufCount)
  );

  // sequencer
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_ff <= ST_IDLE;
    else if (clkEn)
    begin
      case (state_ff)
        ST_IDLE:
          if (cmdTaken)
            state_ff <= ST_SETUP;
        ST_SETUP:
          case (cmd_ff)
            CMD_WRBUF: state_ff <= ST_PIO;
            CMD_WRDMA: state_ff <= eightBitMode ? ST_IDLE : ST_DMA; // [RULE_16]
            default: state_ff <= ST_IDLE; // standby and no-ops finish here
          endcase
        ST_PIO:
          if (pioWord && wordCnt_ff == `ATC_WORD_LAST)
            state_ff <= ST_FINISH;
        ST_DMA:
          // one interrupt for the whole run; sector ends do not stop it
          if (dmaErr || (secDone && sectLeft_ff == `ATC_ONE_SEC))
            state_ff <= ST_FINISH; // [RULE_13]
        ST_FINISH:
          state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // command class and sleep; any accepted command wakes the device
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_ff <= CMD_NONE;
      sleep_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (cmdTaken)
      begin
        cmd_ff <= kind;
        sleep_ff <= 1'b0; // [RULE_03]
      end
      else if (state_ff == ST_SETUP && cmd_ff == CMD_STBY)
        sleep_ff <= 1'b1; // [RULE_01] [RULE_02]
    end
  end

  // busy and drq
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_ff <= 1'b0;
      drq_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (cmdTaken)
        busy_ff <= 1'b1; // [RULE_01] [RULE_02] [RULE_09]
      else if (state_ff == ST_SETUP)
      begin
        busy_ff <= 1'b0;
        // write buffer, and dma write outside 8-bit mode, hand over to the host with drq, no interrupt yet
        drq_ff <= cmd_ff == CMD_WRBUF || (cmd_ff == CMD_WRDMA && !eightBitMode); // [RULE_17] [RULE_09]
      end
      else if (state_ff == ST_PIO && pioWord && wordCnt_ff == `ATC_WORD_LAST)
      begin
        busy_ff <= 1'b1;
        drq_ff <= 1'b0;
      end
      else if (state_ff == ST_DMA)
      begin
        if (dmaErr || (secDone && sectLeft_ff == `ATC_ONE_SEC))
        begin
          busy_ff <= 1'b1;
          drq_ff <= 1'b0;
        end
        else if (hostLeftNext == 17'h0)
          drq_ff <= 1'b0;
      end
      else if (state_ff == ST_FINISH)
        busy_ff <= 1'b0;
    end
  end

  // interrupt: raised at command end, cleared by a status read or a new command
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      intrq_ff <= 1'b0;
    else if (clkEn)
    begin
      // a completion in the same cycle as the clear is kept
      if ((state_ff == ST_SETUP && cmd_ff != CMD_WRBUF && !(cmd_ff == CMD_WRDMA && !eightBitMode))
          || state_ff == ST_FINISH)
        intrq_ff <= 1'b1; // [RULE_01] [RULE_02] [RULE_13]
      else if (statusRead || cmdTaken)
        intrq_ff <= 1'b0;
    end
  end

  // error register; aborted for dma write in 8-bit mode, id-not-found for media failure
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      err_ff <= `ATC_ERR_NONE;
      errStat_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (cmdTaken)
      begin
        err_ff <= `ATC_ERR_NONE;
        errStat_ff <= 1'b0;
      end
      else if (state_ff == ST_SETUP && cmd_ff == CMD_WRDMA && eightBitMode)
      begin
        err_ff[`ATC_ERR_ABRT] <= 1'b1; // [RULE_16]
        errStat_ff <= 1'b1;
      end
      else if (dmaErr)
      begin
        err_ff[`ATC_ERR_IDNF] <= 1'b1; // [RULE_15]
        errStat_ff <= 1'b1;
      end
    end
  end

  // task-file image: loaded on accept, zeroed count for no-ops, advanced between sectors
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      tf_ff <= '0;
    else if (clkEn)
    begin
      if (cmdTaken)
        tf_ff <= tfIn; // [RULE_08]
      else if (state_ff == ST_SETUP && cmd_ff == CMD_NOP)
        tf_ff.secCount <= `ATC_ZERO_COUNT; // [RULE_04] [RULE_05]
      // advance only between sectors: the last one stays, an error freezes it
      else if (state_ff == ST_DMA && !dmaErr && secDone && sectLeft_ff != `ATC_ONE_SEC)
        tf_ff <= nextAddr(tf_ff); // [RULE_14] [RULE_15]
    end
  end

  // word and sector counters
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wordCnt_ff <= `ATC_WORD_ZERO;
      sectLeft_ff <= 9'h0;
      hostLeft_ff <= 17'h0;
    end
    else if (clkEn)
    begin
      if (state_ff == ST_SETUP)
      begin
        wordCnt_ff <= `ATC_WORD_ZERO;
        // zero in the count register means 256 sectors
        sectLeft_ff <= (tf_ff.secCount == `ATC_ZERO_COUNT) ? `ATC_SEC_256
                       : {1'b0, tf_ff.secCount}; // [RULE_07]
        hostLeft_ff <= (tf_ff.secCount == `ATC_ZERO_COUNT) ? {`ATC_SEC_256, `ATC_WORD_SHIFT}
                       : {1'b0, tf_ff.secCount, `ATC_WORD_SHIFT}; // [RULE_12]
      end
      else
      begin
        if (pioWord || dmaWord)
          wordCnt_ff <= wordCnt_ff + 8'h01;
        hostLeft_ff <= hostLeftNext;
        if (state_ff == ST_DMA && secDone)
          sectLeft_ff <= sectLeft_ff - 9'h001;
      end
    end
  end

  // request pin follows room in the buffer and words still owed
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      dmaReq_ff <= 1'b0;
    else if (clkEn)
    begin
      if (state_ff == ST_SETUP)
        dmaReq_ff <= cmd_ff == CMD_WRDMA && !eightBitMode; // [RULE_10]
      else if (state_ff == ST_DMA)
        dmaReq_ff <= !dmaErr && !(secDone && sectLeft_ff == `ATC_ONE_SEC)
                     && hostLeftNext != 17'h0 && !bufFullNext; // [RULE_10]
      else
        dmaReq_ff <= 1'b0;
    end
  end

  // sector buffer: the whole block is overwritten by write buffer
  always_ff @(posedge core_clk)
  begin
    if (clkEn)
    begin
      if (pioWord)
        secBuf[wordCnt_ff] <= hostWrData; // [RULE_06]
      sbRdData_ff <= secBuf[sbRdAddr];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n || !clkEn);

  a_standby_sleep: assert property ((cmdTaken && cmdCode inside {`ATC_OP_STBY_A, `ATC_OP_STBY_B}) // [RULE_01]
    |=> busy_ff ##1 (!busy_ff && intrq_ff && sleep_ff)) else $error("standby did not sleep");
  a_stbyi_sleep: assert property ((cmdTaken && cmdCode inside {`ATC_OP_STBYI_A, `ATC_OP_STBYI_B}) // [RULE_02]
    |=> busy_ff ##1 (!busy_ff && intrq_ff && sleep_ff)) else $error("standby immediate failed");
  a_wake_cmd: assert property ((sleep_ff && cmdTaken) |=> !sleep_ff) else $error("no wake"); // [RULE_03]
  a_xlate_zero: assert property ((cmdTaken && cmdCode == `ATC_OP_XLATE) // [RULE_04]
    |-> ##2 (tf_ff.secCount == `ATC_ZERO_COUNT && intrq_ff)) else $error("translate count");
  a_wear_zero: assert property ((cmdTaken && cmdCode == `ATC_OP_WEAR) // [RULE_05]
    |-> ##2 (tf_ff.secCount == `ATC_ZERO_COUNT && !err_ff[`ATC_ERR_ABRT])) else $error("wear count");
  a_drq_no_intr: assert property ($rose(drq_ff) |-> (!busy_ff && !intrq_ff)) else $error("early irq"); // [RULE_17]
  a_dma_count: assert property ((cmdTaken && kind == CMD_WRDMA && !eightBitMode) |-> ##2 // [RULE_07]
    (sectLeft_ff == (($past(tfIn.secCount, 2) == `ATC_ZERO_COUNT) ? `ATC_SEC_256 : {1'b0, $past(tfIn.secCount, 2)})))
    else $error("dma count");
  a_dma_req_room: assert property (dmaReq_ff |-> (bufReady && hostLeft_ff != 17'h0)) else $error("req"); // [RULE_10]
  a_dma_no_mid: assert property ((state_ff == ST_DMA) |-> !intrq_ff) else $error("mid irq"); // [RULE_13]
  a_err_hold: assert property (dmaErr |=> ($stable(tf_ff) && !dmaReq_ff) ##1 (intrq_ff && errStat_ff)) // [RULE_15]
    else $error("error stop");
  a_abort_8bit: assert property ((cmdTaken && kind == CMD_WRDMA && eightBitMode) |-> ##2 // [RULE_16]
    (err_ff[`ATC_ERR_ABRT] && intrq_ff && !dmaReq_ff && !drq_ff)) else $error("no abort");
endmodule
`default_nettype wire

// >>> atc_host_model.sv
// host model: feeds numbered 16-bit words to the command core by pio or dma
// assumes drq and dmaReq from the core; the bench sets mode, pace and word limit
`timescale 1ns/1ps
`default_nettype none
module atc_host_model
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run, // feed words while high
  input wire logic dmaMode, // high = dma, low = pio
  input wire logic slow, // one idle cycle after each word
  input wire logic [16:0] wordLimit,
  input wire logic drq,
  input wire logic dmaReq,
  output logic hostWrStrobe,
  output logic [15:0] hostWrData,
  output logic dmaAckN,
  output logic [16:0] sent
);
  logic taken; // word accepted at this edge
  logic [16:0] nxtSent;
  assign taken = hostWrStrobe && (dmaMode ? (dmaReq && !dmaAckN) : drq);
  assign nxtSent = sent + {16'h0000, taken};
  // strobe and data are held until taken; idle data toggles so no stale word looks valid
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      hostWrStrobe <= 1'b0;
      hostWrData <= 16'h0000;
      dmaAckN <= 1'b1;
      sent <= 17'h00000;
    end
    else
    begin
      dmaAckN <= !(run && dmaMode);
      sent <= run ? nxtSent : 17'h00000;
      if (hostWrStrobe && !taken && run)
        hostWrStrobe <= 1'b1;
      else if (run && nxtSent < wordLimit && !(slow && taken))
      begin
        hostWrStrobe <= 1'b1;
        hostWrData <= nxtSent[15:0] + 16'h1000;
      end
      else
      begin
        hostWrStrobe <= 1'b0;
        hostWrData <= ~hostWrData;
      end
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
// testbench for the command core: standby, no-op, write buffer and dma write
// assumes atc_pkg, atc_regs.svh and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import atc_pkg::*;
  logic core_clk, reset_n, clkEn, devSelect, eightBitMode, cmdWrite, statusRead;
  logic [7:0] cmdCode, sbRdAddr;
  atc_taskfile_t tfIn, tfOut;
  logic hostWrStrobe, dmaAckN, mediaReady, mediaErr, busy, drq, intrq, dmaReq, sleeping, errStat, mediaValid;
  logic [15:0] hostWrData, sbRdData;
  logic [7:0] errorReg;
  atc_word_t mediaWord;
  logic run, dmaMode, slow, slowMedia, intrqPrev;
  logic [16:0] wordLimit, sent;
  int err_total, checks, mediaCnt, intrqRise;
  logic [7:0] ops [8];

  atc_cmd_core DUT (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .devSelect(devSelect),
    .eightBitMode(eightBitMode), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .tfIn(tfIn),
    .statusRead(statusRead), .hostWrStrobe(hostWrStrobe), .hostWrData(hostWrData), .dmaAckN(dmaAckN),
    .mediaReady(mediaReady), .mediaErr(mediaErr), .sbRdAddr(sbRdAddr), .busy(busy), .drq(drq),
    .intrq(intrq), .dmaReq(dmaReq), .sleeping(sleeping), .errorReg(errorReg), .errStat(errStat),
    .tfOut(tfOut), .mediaValid(mediaValid), .mediaWord(mediaWord), .sbRdData(sbRdData));
  atc_host_model host (.core_clk(core_clk), .reset_n(reset_n), .run(run), .dmaMode(dmaMode), .slow(slow),
    .wordLimit(wordLimit), .drq(drq), .dmaReq(dmaReq), .hostWrStrobe(hostWrStrobe),
    .hostWrData(hostWrData), .dmaAckN(dmaAckN), .sent(sent));

  // 250 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // media sink: stalls every other cycle when asked, checks word order and sector ends
  always @(posedge core_clk)
  begin
    mediaReady <= slowMedia ? ~mediaReady : 1'b1;
    intrqPrev <= intrq;
    if (intrq && !intrqPrev)
      intrqRise++;
    if (mediaValid && mediaReady)
    begin
      chk({1'b0, mediaWord.data}, {1'b0, mediaCnt[15:0] + 16'h1000}, "media data");
      chk({16'h0, mediaWord.sectorEnd}, {16'h0, mediaCnt[7:0] == 8'hff}, "sector end");
      mediaCnt++;
    end
  end

  // one command write; ends just after the taking edge
  task automatic cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] num, input logic [7:0] dh);
    @(posedge core_clk);
    cmdWrite <= 1'b1;
    cmdCode <= op;
    tfIn <= {8'h3c, cnt, num, 8'h00, 8'h00, dh};
    @(posedge core_clk);
    cmdWrite <= 1'b0;
    #1;
  endtask

  // busy must show within a few cycles and last exactly one
  task automatic waitBusy;
    for (int i = 0; i < 3 && busy !== 1'b1; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk({16'h0, busy}, 17'h1, "busy set");
    @(posedge core_clk);
    #1;
    chk({16'h0, busy}, 17'h0, "busy clear");
  endtask

  task automatic waitIntrq(input int lim);
    for (int i = 0; i < lim && intrq !== 1'b1; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk({16'h0, intrq}, 17'h1, "interrupt");
  endtask

  task automatic clrInt;
    @(posedge core_clk);
    statusRead <= 1'b1;
    @(posedge core_clk);
    statusRead <= 1'b0;
    #1;
    chk({16'h0, intrq}, 17'h0, "interrupt cleared");
  endtask

  // dma write of cnt sectors from lba num, limit words offered by the host
  task automatic dmaWrite(input logic [7:0] cnt, input logic [7:0] num, input logic [16:0] lim, input logic pace);
    mediaCnt = 0;
    intrqRise = 0;
    slow <= pace;
    slowMedia <= pace;
    cmd(8'hca, cnt, num, 8'he0);
    waitBusy;
    chk({15'h0, drq, intrq}, 17'h2, "drq without interrupt");
    @(posedge core_clk);
    #1;
    chk({16'h0, dmaReq}, 17'h1, "dma request");
    run <= 1'b1;
    dmaMode <= 1'b1;
    wordLimit <= lim;
    waitIntrq(70000);
    // let the sink's edge counter see the rise before anyone reads it
    @(posedge core_clk);
    #1;
    run <= 1'b0;
    slowMedia <= 1'b0;
  endtask

  initial
  begin
    #320000;
    err_total++;
    wrap_up;
  end

  initial
  begin
    ops = '{8'h96, 8'h87, 8'he2, 8'hf5, 8'h94, 8'h87, 8'he0, 8'hf5};
    {reset_n, cmdWrite, statusRead, eightBitMode, devSelect, mediaErr, run, dmaMode, slow, slowMedia} = '0;
    {clkEn, mediaReady} = 2'b11;
    {cmdCode, sbRdAddr, tfIn, wordLimit, intrqPrev} = '0;
    err_total = 0;
    checks = 0;
    mediaCnt = 0;
    intrqRise = 0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk({11'h0, busy, drq, intrq, dmaReq, sleeping, errStat}, 17'h0, "reset flags");
    chk({1'b0, tfOut[47:32]}, 17'h0, "reset task file");
    // standby opcodes alternate with no-ops, which must also wake the device
    for (int i = 0; i < 8; i++)
    begin
      cmd(ops[i], 8'h55, 8'h21, 8'h0f);
      waitBusy;
      chk({16'h0, intrq}, 17'h1, "done interrupt");
      chk({16'h0, sleeping}, {16'h0, i % 2 == 0}, "sleep flag");
      if (i % 2 == 1)
        chk({9'h0, tfOut.secCount}, 17'h0, "no-op count");
      clrInt;
    end
    // a command for the other drive is ignored
    cmd(8'h96, 8'h00, 8'h00, 8'h10);
    repeat (3) @(posedge core_clk);
    #1;
    chk({15'h0, busy, sleeping}, 17'h0, "other drive");
    // write buffer: one block by pio, then read back
    cmd(8'he8, 8'h00, 8'h00, 8'h00);
    waitBusy;
    chk({15'h0, drq, intrq}, 17'h2, "pio drq");
    dmaMode <= 1'b0;
    wordLimit <= 17'h00100;
    run <= 1'b1;
    waitIntrq(400);
    chk(sent, 17'h00100, "block words");
    run <= 1'b0;
    clrInt;
    for (int a = 0; a < 256; a += 85)
    begin
      @(posedge core_clk);
      sbRdAddr <= a[7:0];
      repeat (2) @(posedge core_clk);
      #1;
      chk({1'b0, sbRdData}, {1'b0, a[15:0] + 16'h1000}, "buffer word");
    end
    // dma write refused in 8-bit mode
    @(posedge core_clk);
    eightBitMode <= 1'b1;
    cmd(8'hca, 8'h01, 8'h00, 8'he0);
    waitBusy;
    chk({14'h0, intrq, errorReg[2], errStat}, 17'h7, "abort");
    @(posedge core_clk);
    eightBitMode <= 1'b0;
    clrInt;
    // two sectors with a slow host and a stalling sink
    dmaWrite(8'h02, 8'h40, 17'h00200, 1'b1);
    chk(mediaCnt[16:0], 17'h00200, "two sectors");
    chk({9'h0, tfOut.secNum}, 17'h41, "last address");
    chk(intrqRise[16:0], 17'h1, "one interrupt");
    clrInt;
    // count zero moves 256 sectors
    dmaWrite(8'h00, 8'h00, 17'h10000, 1'b0);
    chk(mediaCnt[16:0], 17'h10000, "256 sectors");
    chk({9'h0, tfOut.secNum}, 17'hff, "last address");
    clrInt;
    // media failure in the second of three sectors
    fork
      dmaWrite(8'h03, 8'h10, 17'h00300, 1'b0);
      begin
        wait (mediaCnt == 300);
        @(posedge core_clk);
        mediaErr <= 1'b1;
        @(posedge core_clk);
        mediaErr <= 1'b0;
      end
    join
    chk({15'h0, errorReg[4], errStat}, 17'h3, "media error");
    chk({9'h0, tfOut.secNum}, 17'h11, "failing address");
    chk(intrqRise[16:0], 17'h1, "error interrupt");
    wrap_up;
  end
endmodule
`default_nettype wire
